// *** shared/cstg_pkg.sv ***
// Purpose: Shared constants and types for the CRT sync timing generator.
// Assumes: One master clock at the dot rate; all counts are in dot, character or line periods.
// Notes:   Line decodes hold both frame-rate models; a mode input picks one.
`default_nettype none
package cstg_pkg;
   localparam int unsigned DOT_CLOCK_HZ    = 9828000;
   localparam int unsigned DOTS_PER_CHAR   = 6;
   localparam logic [2:0]  DOT_LAST        = 3'h5;
   localparam logic [2:0]  DOT_ARM         = 3'h4;
   localparam int unsigned COL_W           = 7;
   localparam int unsigned LINE_W          = 9;
   localparam logic [6:0]  COL_LAST        = 7'h68;
   localparam logic [6:0]  COL_VIDEO_OFF   = 7'h52;
   localparam logic [6:0]  COL_ROW_STEP    = 7'h51;
   localparam logic [6:0]  COL_HSYNC_ON    = 7'h58;
   localparam logic [6:0]  COL_HSYNC_OFF   = 7'h14;
   localparam logic [8:0]  LINE_WIN_ON     = 9'h010;
   localparam logic [8:0]  LINE_WIN_OFF    = 9'h100;
   localparam logic [8:0]  LINE_VS_60      = 9'h104;
   localparam logic [8:0]  LINE_VS_50      = 9'h138;
   localparam logic [8:0]  LINE_VS_OFF     = 9'h005;
   localparam logic [3:0]  SCAN_ROW_LAST   = 4'h9;
   localparam int unsigned COL_BIT1        = 1;
   localparam int unsigned COL_BIT6        = 6;

   typedef enum logic [1:0] {
      CSTG_PH_IDLE  = 2'b00,
      CSTG_PH_ARMED = 2'b01,
      CSTG_PH_FIRE  = 2'b10
   } cstg_phase_t;
endpackage : cstg_pkg
`default_nettype wire

// *** shared/cstg_dot_if.sv ***
// Purpose: Carries dot-level timing from the dot divider to the main generator.
// Assumes: Single clock domain.
// Notes:   char_adv and char_strobe are one-cycle pulses; dot_shift is a level held high out of reset.
`default_nettype none
interface cstg_dot_if;
   logic char_adv;
   logic char_strobe;
   logic dot_shift;
   modport divider (output char_adv, output char_strobe, output dot_shift);
   modport user    (input char_adv, input char_strobe, input dot_shift);
endinterface : cstg_dot_if
`default_nettype wire

// *** rtl/cstg_dot_divider.sv ***
// Purpose: Modulo-six dot divider that forms the character advance and strobes.
// Assumes: mclk runs at the dot rate; each clock is one dot.
// Notes:   Half-dot pulses become whole-clock pulses at this single-clock rate.
`default_nettype none
module cstg_dot_divider
   import cstg_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   cstg_dot_if.divider dot
);
   logic [2:0]  dot_divider_q;
   logic [2:0]  dot_divider_d;
   cstg_phase_t phase_q;
   cstg_phase_t phase_d;
   wire         last_dot = (dot_divider_q == DOT_LAST);
   wire         arm_dot  = (dot_divider_q == DOT_ARM);

   assign dot_divider_d = last_dot ? 3'h0 : dot_divider_q + 3'h1;

   // The advance is armed one dot ahead and fires on the sixth dot, as the
   // falling-then-rising edge pair did in the original half-dot timing.
   always_comb begin
      case (phase_q)
         CSTG_PH_IDLE:  phase_d = arm_dot ? CSTG_PH_ARMED : CSTG_PH_IDLE;
         CSTG_PH_ARMED: phase_d = CSTG_PH_FIRE;
         CSTG_PH_FIRE:  phase_d = arm_dot ? CSTG_PH_ARMED : CSTG_PH_IDLE;
         default:       phase_d = CSTG_PH_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dot_divider_q <= 3'h0;
         phase_q       <= CSTG_PH_IDLE;
      end else begin
         dot_divider_q <= dot_divider_d;
         phase_q       <= phase_d;
      end
   end

   assign dot.char_adv    = (phase_q == CSTG_PH_FIRE);
   assign dot.char_strobe = last_dot;
   assign dot.dot_shift   = !rst;
endmodule : cstg_dot_divider
`default_nettype wire

// *** rtl/cstg_timing_gen.sv ***
// Purpose: Column, line and scan-row timing with sync and video gating for a CRT.
// Assumes: mclk is the dot clock; rate_50hz is steady or changed only in reset.
// Notes:   All outputs are registered; sync outputs are active high here.
`default_nettype none
// What this block does
// - Every timing signal is derived from the single dot clock and nothing else.
// - A dot divider counts modulo six so that a character lasts six dots.
// - The divider arms the advance a dot early and emits an active-high advance on the sixth dot, output inverted as char_adv_n.
// - The column counter spans 105 positions, of which 80 show characters.
// - At column 104 the counter is loaded so that the next advance returns it to zero.
// - The column is a seven-bit value whose upper five bits address the sync decode.
// - The video gate loads the display-window flag when column bit 1 rises with bit 6 low.
// - While the gate is set, character strobes, dot shifts and video enable pass out.
// - Display starts at column 2, giving a two-character left margin.
// - Horizontal sync asserts at column 88 and deasserts at column 20.
// - A nine-bit line counter counts horizontal sync pulses from the start of vertical sync.
// - The line counter resets at 260 for 60 Hz or 312 for 50 Hz, with vertical sync start.
// - The display-window flag sets at line 16 and clears at line 256.
// - Vertical sync sets at 260 or 312 and clears at line 5.
module cstg_timing_gen
   import cstg_pkg::*;
#(
   parameter logic [LINE_W-1:0]   WIN_ON_LINE  = LINE_WIN_ON,
   parameter logic [LINE_W-1:0]   WIN_OFF_LINE = LINE_WIN_OFF,
   parameter logic [LINE_W-1:0]   VS_LINE_60   = LINE_VS_60,
   parameter logic [LINE_W-1:0]   VS_LINE_50   = LINE_VS_50,
   parameter logic [LINE_W-1:0]   VS_OFF_LINE  = LINE_VS_OFF
)
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              rate_50hz,
   output logic                   char_adv_n,
   output logic [COL_W-1:0]       column_count,
   output logic [LINE_W-1:0]      line_count,
   output logic [3:0]             scan_row,
   output logic                   hsync,
   output logic                   vsync,
   output logic                   display_window,
   output logic                   video_gate,
   output logic                   char_strobe_n,
   output logic                   dot_shift_n,
   output logic                   video_enable
);
   cstg_dot_if dot ();

   cstg_dot_divider u_div (
      .mclk (mclk),
      .rst  (rst),
      .dot  (dot)
   );

   function automatic logic col_is(input logic [COL_W-1:0] c, input logic [COL_W-1:0] v);
      return c == v;
   endfunction : col_is

   logic [COL_W-1:0]  col_q;
   logic [COL_W-1:0]  col_d;
   logic [LINE_W-1:0] line_counter_q;
   logic [LINE_W-1:0] line_counter_d;
   logic [3:0]        scan_row_counter_q;
   logic              hsync_q;
   logic              vertical_sync_flop_q;
   logic              display_window_flop_q;
   logic              gate_q;
   logic              gate_d;
   logic              col_bit1_prev_q;
   logic              row_step_q;

   wire               adv         = dot.char_adv;
   wire               col_load    = col_is(col_q, COL_LAST);
   // Decoding the next column lets sync change on the very edge that the
   // column reaches its decode value, not one character later.
   wire [4:0]         sync_addr   = col_d[COL_W-1:2];
   wire               hs_on_hit   = (sync_addr == COL_HSYNC_ON[COL_W-1:2]) &&
                                    col_is(col_d, COL_HSYNC_ON);
   wire               hs_off_hit  = (sync_addr == COL_HSYNC_OFF[COL_W-1:2]) &&
                                    col_is(col_d, COL_HSYNC_OFF);
   wire               hs_start    = adv && hs_on_hit && !hsync_q;
   wire               column_bit1 = col_q[COL_BIT1];
   wire               column_bit6 = col_q[COL_BIT6];
   wire               gate_clk    = column_bit1 && !col_bit1_prev_q && !column_bit6;
   wire               gate_off    = col_is(col_q, COL_VIDEO_OFF);
   wire               row_hit     = col_is(col_q, COL_ROW_STEP);
   wire [LINE_W-1:0]  vs_line     = rate_50hz ? VS_LINE_50 : VS_LINE_60;
   wire [LINE_W-1:0]  vs_last     = vs_line - 9'h001;
   wire               line_wrap   = (line_counter_q == vs_last);

   assign col_d = col_load ? '0 : col_q + 7'h01;

   // The count that would reach the vertical-sync line becomes zero instead,
   // so a frame holds exactly that many lines; the same wrap opens sync.
   assign line_counter_d = line_wrap ? '0 : line_counter_q + 9'h001;

   // Column 2 is the first value with bit 1 rising and bit 6 low, so the gate
   // opens there; column 82 has bit 6 set, so the reset has sole control.
   assign gate_d = gate_off ? 1'b0 : (gate_clk ? display_window_flop_q : gate_q);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         col_q <= '0;
      end else if (adv) begin
         col_q <= col_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hsync_q <= 1'b0;
      end else if (adv && hs_on_hit) begin
         hsync_q <= 1'b1;
      end else if (adv && hs_off_hit) begin
         hsync_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_counter_q <= '0;
      end else if (hs_start) begin
         line_counter_q <= line_counter_d;
      end
   end

   // The flags follow the count that each new line brings, so a wrap to zero
   // raises vertical sync on the same line the count restarts.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vertical_sync_flop_q  <= 1'b0;
         display_window_flop_q <= 1'b0;
      end else if (hs_start) begin
         if (line_wrap) begin
            vertical_sync_flop_q <= 1'b1;
         end else if (line_counter_d == VS_OFF_LINE) begin
            vertical_sync_flop_q <= 1'b0;
         end
         if (line_counter_d == WIN_ON_LINE) begin
            display_window_flop_q <= 1'b1;
         end else if (line_counter_d == WIN_OFF_LINE) begin
            display_window_flop_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_q          <= 1'b0;
         col_bit1_prev_q <= 1'b0;
         row_step_q      <= 1'b0;
      end else begin
         gate_q          <= gate_d;
         col_bit1_prev_q <= column_bit1;
         row_step_q      <= row_hit;
      end
   end

   // One step per line: only the first cycle of column 81 counts.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scan_row_counter_q <= 4'h0;
      end else if (row_hit && !row_step_q) begin
         scan_row_counter_q <= (scan_row_counter_q == SCAN_ROW_LAST) ? 4'h0 :
                               scan_row_counter_q + 4'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         char_adv_n     <= 1'b1;
         column_count   <= '0;
         line_count     <= '0;
         scan_row       <= 4'h0;
         hsync          <= 1'b0;
         vsync          <= 1'b0;
         display_window <= 1'b0;
         video_gate     <= 1'b0;
         char_strobe_n  <= 1'b1;
         dot_shift_n    <= 1'b1;
         video_enable   <= 1'b0;
      end else begin
         char_adv_n     <= !adv;
         column_count   <= col_q;
         line_count     <= line_counter_q;
         scan_row       <= scan_row_counter_q;
         hsync          <= hsync_q;
         vsync          <= vertical_sync_flop_q;
         display_window <= display_window_flop_q;
         video_gate     <= gate_q;
         char_strobe_n  <= !(gate_q && dot.char_strobe);
         dot_shift_n    <= !(gate_q && dot.dot_shift);
         video_enable   <= gate_q;
      end
   end
endmodule : cstg_timing_gen
`default_nettype wire

// *** sim/cstg_chk.sv ***
// Purpose: Port-level assertions for the CRT sync timing generator.
// Assumes: One clock; outputs registered.
// Notes:   The hsync, gate-off and window edge checks allow one cycle of output lag.
`default_nettype none
module cstg_chk
   import cstg_pkg::*;
#(
   parameter logic [LINE_W-1:0] WIN_ON_LINE  = LINE_WIN_ON,
   parameter logic [LINE_W-1:0] WIN_OFF_LINE = LINE_WIN_OFF,
   parameter logic [LINE_W-1:0] VS_OFF_LINE  = LINE_VS_OFF
)
(
   input wire logic         mclk,
   input wire logic         rst,
   input wire logic         char_adv_n,
   input wire logic [6:0]   column_count,
   input wire logic [8:0]   line_count,
   input wire logic         hsync,
   input wire logic         vsync,
   input wire logic         display_window,
   input wire logic         video_gate
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence adv_gap_s;
      char_adv_n [*5] ##1 !char_adv_n;
   endsequence
   adv_period_a: assert property ($fell(char_adv_n) |=> adv_gap_s)
      else $error("advance spacing wrong");
   col_step_a: assert property ($changed(column_count) |-> column_count ==
      (($past(column_count) == COL_LAST) ? 7'h00 : $past(column_count) + 7'h01))
      else $error("column step wrong");
   col_hold_a: assert property ($changed(column_count) |=> $stable(column_count) [*5])
      else $error("column held too short");
   hsync_on_a: assert property ($rose(hsync) |->
      ##[0:1] column_count == COL_HSYNC_ON) else $error("hsync rose off column");
   hsync_off_a: assert property ($fell(hsync) |->
      ##[0:1] column_count == COL_HSYNC_OFF) else $error("hsync fell off column");
   gate_on_a: assert property ($rose(video_gate) |->
      display_window && column_count == 7'h02) else $error("gate rose wrongly");
   gate_off_a: assert property ($fell(video_gate) |->
      ##[0:1] column_count == COL_VIDEO_OFF) else $error("gate fell off column");
   win_on_a: assert property ($rose(display_window) |->
      ##[0:1] line_count == WIN_ON_LINE) else $error("window set off line");
   win_off_a: assert property ($fell(display_window) |->
      ##[0:1] line_count == WIN_OFF_LINE) else $error("window cleared off line");
   line_step_a: assert property ($changed(line_count) |-> ##[0:1] hsync ##0
      (line_count == 9'h000 || line_count == $past(line_count) + 9'h001))
      else $error("line step wrong");
   vs_on_a: assert property ($rose(vsync) |-> line_count == 9'h000)
      else $error("vsync rose off line");
   vs_off_a: assert property ($fell(vsync) |-> line_count == VS_OFF_LINE)
      else $error("vsync fell off line");
endmodule : cstg_chk
bind cstg_timing_gen cstg_chk #(
   .WIN_ON_LINE  (WIN_ON_LINE),
   .WIN_OFF_LINE (WIN_OFF_LINE),
   .VS_OFF_LINE  (VS_OFF_LINE)
) u_chk (
   .mclk           (mclk),
   .rst            (rst),
   .char_adv_n     (char_adv_n),
   .column_count   (column_count),
   .line_count     (line_count),
   .hsync          (hsync),
   .vsync          (vsync),
   .display_window (display_window),
   .video_gate     (video_gate)
);
`default_nettype wire

// *** sim/cstg_monitor_model.sv ***
// Purpose: Monitor model that times the sync pulses it receives.
// Assumes: Sync inputs are active high levels.
// Notes:   The first period after reset is meaningless and is never read.
`default_nettype none
module cstg_monitor_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsync,
   input wire logic vsync,
   output var int   hs_per,
   output var int   hs_wid,
   output var int   vs_wid
);
   timeunit 1ns;
   timeprecision 1ps;
   int   t_q, hs_t_q, vs_t_q;
   logic hs_q, vs_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         t_q <= 0;
         hs_q <= 1'b0;
         vs_q <= 1'b0;
      end else begin
         t_q <= t_q + 1;
         hs_q <= hsync;
         vs_q <= vsync;
         if (hsync && !hs_q) begin
            hs_per <= t_q - hs_t_q;
            hs_t_q <= t_q;
         end
         if (!hsync && hs_q) hs_wid <= t_q - hs_t_q;
         if (vsync && !vs_q) vs_t_q <= t_q;
         if (!vsync && vs_q) vs_wid <= t_q - vs_t_q;
      end
   end
endmodule : cstg_monitor_model
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the CRT sync timing generator.
// Assumes: 40 MHz clock; inputs change on the falling edge.
// Notes:   Frames are shortened through the line parameters; columns keep their real size.
`default_nettype none
module testbench
   import cstg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Short frames keep the run small; the window opens at its real line.
   localparam logic [8:0] WIN_OFF_T = 9'h014;
   localparam logic [8:0] VS60_T    = 9'h018;
   localparam logic [8:0] VS50_T    = 9'h01C;
   logic       mclk, rst, rate_50hz, char_adv_n, hsync, vsync, display_window;
   logic       video_gate, char_strobe_n, dot_shift_n, video_enable;
   logic [6:0] column_count;
   logic [8:0] line_count, top;
   logic [3:0] scan_row;
   int         hs_per, hs_wid, vs_wid, cyc;
   int         err_count = 0;
   int         compares = 0;
   cstg_timing_gen #(
      .WIN_OFF_LINE (WIN_OFF_T),
      .VS_LINE_60   (VS60_T),
      .VS_LINE_50   (VS50_T)
   ) u_dut (.mclk, .rst, .rate_50hz, .char_adv_n, .column_count, .line_count,
      .scan_row, .hsync, .vsync, .display_window, .video_gate, .char_strobe_n, .dot_shift_n,
      .video_enable);
   cstg_monitor_model u_mon (.mclk, .rst, .hsync, .vsync, .hs_per, .hs_wid, .vs_wid);
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Two short frames take about 40000 clocks; the ceiling leaves margin.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (line_count > top) top <= line_count;
      if (cyc == 60000) begin
         err_count++;
         end_of_test;
      end
   end
   task automatic do_reset(input logic r50);
      @(negedge mclk);
      rst = 1'b1;
      rate_50hz = r50;
      repeat (6) @(negedge mclk);
      chk("pulses", 32'h7, {char_adv_n, char_strobe_n, dot_shift_n});
      chk("counts", 32'h0, {column_count, line_count, scan_row, hsync, vsync,
         display_window, video_gate, video_enable});
      top = 9'h000;
      rst = 1'b0;
   endtask : do_reset
   task automatic t_line;
      int g = 0, s = 0, d = 0, v = 0, c = 0;
      logic [3:0] r;
      while (!(display_window && column_count == 7'h00)) @(negedge mclk);
      r = scan_row;
      repeat (630) begin
         @(negedge mclk);
         g += video_gate;
         s += !char_strobe_n;
         d += !dot_shift_n;
         v += video_enable;
         if (column_count > c) c = column_count;
      end
      chk("gate", 480, g);
      chk("strobes", 80, s);
      chk("shifts", 480, d);
      chk("enable", 480, v);
      chk("col max", 104, c);
      chk("row", (r == 4'h9) ? 4'h0 : r + 4'h1, scan_row);
      chk("hs period", 630, hs_per);
      chk("hs width", 222, hs_wid);
   endtask : t_line
   task automatic t_frame(input logic [8:0] last);
      while (!vsync) @(negedge mclk);
      chk("frame top", last - 9'h001, top);
      chk("line wrap", 0, line_count);
      while (vsync) @(negedge mclk);
      chk("vs end", LINE_VS_OFF, line_count);
      // The monitor registers the sync edge a clock late, so let it settle.
      repeat (2) @(negedge mclk);
      chk("vs width", 3150, vs_wid);
   endtask : t_frame
   initial begin
      rst = 1'b1;
      rate_50hz = 1'b0;
      do_reset(1'b0);
      t_line;
      t_frame(VS60_T);
      do_reset(1'b1);
      t_line;
      t_frame(VS50_T);
      end_of_test;
   end
endmodule : testbench
`default_nettype wire
